// File: hdl/plcd_regs.vh
`ifndef PLCD_REGS_VH
`define PLCD_REGS_VH
// register word addresses
`define PLCD_A_CTRL 4'h0
`define PLCD_A_UPLIM 4'h1
`define PLCD_A_LOLIM 4'h2
`define PLCD_A_PANSP 4'h3
`define PLCD_A_DTIME 4'h4
`define PLCD_A_OCLVL 4'h5
`define PLCD_A_OCPER 4'h6
`define PLCD_A_BIAS 4'h7
`define PLCD_A_GAIN 4'h8
`define PLCD_A_STAT 4'h9
`define PLCD_A_IRQST 4'ha
`define PLCD_A_IRQMSK 4'hb
`define PLCD_A_SPD 4'hc
`define PLCD_A_SPMAX 4'hd
`define PLCD_A_SPMIN 4'he
// setting value meaning function disabled
`define PLCD_DISABLE 16'h270f
// ctrl field positions
`define PLCD_C_OPMODE_LO 0
`define PLCD_C_OPMODE_HI 2
`define PLCD_C_TUNE_LO 3
`define PLCD_C_TUNE_HI 4
`define PLCD_C_EXTSP 5
// mode encodings
`define PLCD_OPMODE_SWITCH 3'h6
`define PLCD_TUNE_ONLINE 2'h1
// reset values (percent in 0.1 units, time in ms, dtime in 10 ms)
`define PLCD_RST_OCLVL 16'h05dc
`define PLCD_RST_OCPER 16'h0000
`define PLCD_RST_UPLIM 16'h270f
`define PLCD_RST_LOLIM 16'h270f
`define PLCD_RST_DTIME 16'h270f
`define PLCD_RST_SPMAX 16'hffff
`define PLCD_RST_PERMAX 16'h2710
// full scale of percent settings in 0.1 units
`define PLCD_PCT_FULL 16'h03e8
`define PLCD_PCT_OCMAX 16'h07d0
`define PLCD_DTIME_MIN 16'h0001
`define PLCD_DTIME_MAX 16'h03e8
// timing
`define PLCD_CLK_HZ 125000000
`define PLCD_MS_HZ 1000
`define PLCD_HOLD_MS 16'h0064
`define PLCD_ZERO_MS 16'h0032
// status bits
`define PLCD_S_UP 0
`define PLCD_S_LO 1
`define PLCD_S_OC 2
`define PLCD_S_PID 3
`define PLCD_S_DON 4
`endif

// File: hdl/plcd_ms_timer.v
`timescale 1ns/1ps
`default_nettype none
// millisecond counter: counts tick pulses while run is high, clears otherwise
module plcd_ms_timer #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire run,
  input wire tick,
  output reg [W-1:0] count_r
);
  // saturating count so a long excess never wraps back to zero
  always @(posedge clk) begin
    if (!nrst) begin
      count_r <= {W{1'b0}};
    end else if (!run) begin
      count_r <= {W{1'b0}};
    end else if (tick && (count_r != {W{1'b1}})) begin
      count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// File: hdl/plcd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "plcd_regs.vh"
//Contract
// - flag when feedback above upper limit, 9999 disables
// - alarm when feedback below lower limit
// - panel set point only in panel modes
// - differential time 0.01-10s, 9999 omits it
// - speed select or jog overrides PID
// - operation mode 6 disables PID
// - online tuning selection disables PID
// - PID speed bounded by bias, gain, max, min
// - overcurrent flag after excess outlasts period
// - period timed from rise until flag
// - level 100 percent equals rated current
// - flag held at least 100 ms; code may release it up to one ms early, at the ms tick resolution
// - zero period acts as about 50 ms
// - detection stays active during auto tuning
module plcd_top #(
  parameter MS_DIV = `PLCD_CLK_HZ / `PLCD_MS_HZ,
  parameter RATED = 16'h0400
) (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata_r,
  input wire [15:0] feedback,
  input wire [15:0] out_current,
  input wire [15:0] analog_sp,
  input wire [15:0] pid_speed,
  input wire running,
  input wire tuning_active,
  input wire pid_select_input,
  input wire speed_select_high,
  input wire speed_select_mid,
  input wire speed_select_low,
  input wire jog_input,
  output reg upper_limit_flag_r,
  output reg lower_limit_alarm_r,
  output reg overcurrent_detect_flag_r,
  output reg pid_active_r,
  output reg diff_enable_r,
  output reg [15:0] diff_time_r,
  output reg [15:0] set_point_r,
  output reg [15:0] speed_cmd_r,
  output reg irq_r
);
  // configuration registers
  reg [15:0] ctrl_r;
  reg [15:0] uplim_r;
  reg [15:0] lolim_r;
  reg [15:0] pansp_r;
  reg [15:0] dtime_r;
  reg [15:0] oclvl_r;
  reg [15:0] ocper_r;
  reg [15:0] bias_r;
  reg [15:0] gain_r;
  reg [15:0] spmax_r;
  reg [15:0] spmin_r;
  reg [4:0] irq_st_r;
  reg [4:0] irq_msk_r;
  // previous status for edge events
  reg up_q_r;
  reg lo_q_r;
  reg oc_q_r;
  // millisecond tick divider
  reg [31:0] div_r;
  reg ms_tick_r;
  // overcurrent state machine
  localparam OC_IDLE = 2'h0;
  localparam OC_QUAL = 2'h1;
  localparam OC_HOLD = 2'h2;
  localparam OC_ON = 2'h3;
  reg [1:0] oc_st_r;
  reg [1:0] oc_st_nxt;
  wire [15:0] tmr;
  wire [15:0] hold_tmr;
  // decoded mode fields
  wire [2:0] opmode = ctrl_r[`PLCD_C_OPMODE_HI:`PLCD_C_OPMODE_LO];
  wire [1:0] tune = ctrl_r[`PLCD_C_TUNE_HI:`PLCD_C_TUNE_LO];
  wire ext_op = ctrl_r[`PLCD_C_EXTSP];
  // scaled threshold: level in 0.1 percent of rated current
  wire [31:0] oc_thr = ({16'h0000, oclvl_r} * {16'h0000, RATED}) / {16'h0000, `PLCD_PCT_FULL};
  wire [31:0] up_thr = ({16'h0000, uplim_r} * {16'h0000, RATED}) / {16'h0000, `PLCD_PCT_FULL};
  wire [31:0] lo_thr = ({16'h0000, lolim_r} * {16'h0000, RATED}) / {16'h0000, `PLCD_PCT_FULL};
  // over-level condition; detection does not look at tuning state
  wire over = running && ({16'h0000, out_current} > oc_thr);
  // zero period is replaced by the fixed 50 ms qualification time PLCD_ZERO_MS
  wire [15:0] per_eff = (ocper_r == 16'h0000) ? `PLCD_ZERO_MS : ocper_r;
  wire qual_run = (oc_st_r == OC_QUAL);
  wire hold_run = (oc_st_r == OC_HOLD);
  // pid enable decode
  wire override = speed_select_high | speed_select_mid | speed_select_low | jog_input;
  wire pid_on = pid_select_input && !override
    && (opmode != `PLCD_OPMODE_SWITCH)
    && (tune != `PLCD_TUNE_ONLINE);
  // speed window: pid bounds first, general limits last
  wire [15:0] sp_lo1 = (pid_speed < bias_r) ? bias_r : pid_speed;
  wire [15:0] sp_pid = (sp_lo1 > gain_r) ? gain_r : sp_lo1;
  wire [15:0] sp_in = pid_on ? sp_pid : pid_speed;
  wire [15:0] sp_hi = (sp_in > spmax_r) ? spmax_r : sp_in;
  wire [15:0] sp_out = (sp_hi < spmin_r) ? spmin_r : sp_hi;
  wire up_now = (uplim_r != `PLCD_DISABLE) && ({16'h0000, feedback} > up_thr);
  wire lo_now = (lolim_r != `PLCD_DISABLE) && ({16'h0000, feedback} < lo_thr);
  wire [4:0] ev = {1'b0, pid_on & ~pid_active_r, overcurrent_detect_flag_r & ~oc_q_r,
    lower_limit_alarm_r & ~lo_q_r, upper_limit_flag_r & ~up_q_r};

  // period and hold timers share one millisecond tick
  plcd_ms_timer #(.W(16)) u_qual (
    .clk(clk),
    .nrst(nrst),
    .run(qual_run),
    .tick(ms_tick_r),
    .count_r(tmr)
  );
  plcd_ms_timer #(.W(16)) u_hold (
    .clk(clk),
    .nrst(nrst),
    .run(hold_run),
    .tick(ms_tick_r),
    .count_r(hold_tmr)
  );

  // divider making a one-cycle tick each millisecond
  always @(posedge clk) begin
    if (!nrst) begin
      div_r <= 32'h00000000;
      ms_tick_r <= 1'b0;
    end else if (div_r == MS_DIV - 1) begin
      div_r <= 32'h00000000;
      ms_tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 32'h00000001;
      ms_tick_r <= 1'b0;
    end
  end

  // overcurrent next-state logic; ms resolution means the delay may run up to one ms short
  always @* begin
    oc_st_nxt = oc_st_r;
    case (oc_st_r)
      OC_IDLE: begin
        if (over) begin
          oc_st_nxt = OC_QUAL;
        end
      end
      OC_QUAL: begin
        if (!over) begin
          oc_st_nxt = OC_IDLE;
        end else if (tmr >= per_eff) begin
          oc_st_nxt = OC_HOLD;
        end
      end
      OC_HOLD: begin
        // minimum on time regardless of current
        if (hold_tmr >= `PLCD_HOLD_MS) begin
          oc_st_nxt = over ? OC_ON : OC_IDLE;
        end
      end
      OC_ON: begin
        if (!over) begin
          oc_st_nxt = OC_IDLE;
        end
      end
      default: begin
        oc_st_nxt = OC_IDLE;
      end
    endcase
  end

  // overcurrent state register and flag
  always @(posedge clk) begin
    if (!nrst) begin
      oc_st_r <= OC_IDLE;
      overcurrent_detect_flag_r <= 1'b0;
    end else begin
      oc_st_r <= oc_st_nxt;
      overcurrent_detect_flag_r <= (oc_st_nxt == OC_HOLD) || (oc_st_nxt == OC_ON);
    end
  end

  // limit flags, pid outputs and speed command
  always @(posedge clk) begin
    if (!nrst) begin
      upper_limit_flag_r <= 1'b0;
      lower_limit_alarm_r <= 1'b0;
      pid_active_r <= 1'b0;
      diff_enable_r <= 1'b0;
      diff_time_r <= 16'h0000;
      set_point_r <= 16'h0000;
      speed_cmd_r <= 16'h0000;
    end else begin
      upper_limit_flag_r <= up_now;
      lower_limit_alarm_r <= lo_now;
      pid_active_r <= pid_on;
      // differential term off at the disable value
      diff_enable_r <= pid_on && (dtime_r != `PLCD_DISABLE);
      diff_time_r <= (dtime_r == `PLCD_DISABLE) ? 16'h0000 : dtime_r;
      // panel value only when not in external operation
      set_point_r <= ext_op ? analog_sp : pansp_r;
      speed_cmd_r <= sp_out;
    end
  end

  // register writes; out-of-range values are clipped to the legal span
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= 16'h0000;
      uplim_r <= `PLCD_RST_UPLIM;
      lolim_r <= `PLCD_RST_LOLIM;
      pansp_r <= 16'h0000;
      dtime_r <= `PLCD_RST_DTIME;
      oclvl_r <= `PLCD_RST_OCLVL;
      ocper_r <= `PLCD_RST_OCPER;
      bias_r <= 16'h0000;
      gain_r <= 16'hffff;
      spmax_r <= `PLCD_RST_SPMAX;
      spmin_r <= 16'h0000;
      irq_msk_r <= 5'h00;
    end else if (wr) begin
      case (addr)
        `PLCD_A_CTRL: ctrl_r <= wdata;
        `PLCD_A_UPLIM: begin
          uplim_r <= (wdata == `PLCD_DISABLE || wdata <= `PLCD_PCT_FULL) ? wdata : `PLCD_PCT_FULL;
        end
        `PLCD_A_LOLIM: begin
          lolim_r <= (wdata == `PLCD_DISABLE || wdata <= `PLCD_PCT_FULL) ? wdata : `PLCD_PCT_FULL;
        end
        `PLCD_A_PANSP: pansp_r <= (wdata > `PLCD_PCT_FULL) ? `PLCD_PCT_FULL : wdata;
        `PLCD_A_DTIME: begin
          if (wdata == `PLCD_DISABLE) begin
            dtime_r <= wdata;
          end else if (wdata < `PLCD_DTIME_MIN) begin
            dtime_r <= `PLCD_DTIME_MIN;
          end else begin
            dtime_r <= (wdata > `PLCD_DTIME_MAX) ? `PLCD_DTIME_MAX : wdata;
          end
        end
        `PLCD_A_OCLVL: oclvl_r <= (wdata > `PLCD_PCT_OCMAX) ? `PLCD_PCT_OCMAX : wdata;
        `PLCD_A_OCPER: ocper_r <= (wdata > `PLCD_RST_PERMAX) ? `PLCD_RST_PERMAX : wdata;
        `PLCD_A_BIAS: bias_r <= wdata;
        `PLCD_A_GAIN: gain_r <= wdata;
        `PLCD_A_SPMAX: spmax_r <= wdata;
        `PLCD_A_SPMIN: spmin_r <= wdata;
        `PLCD_A_IRQMSK: irq_msk_r <= wdata[4:0];
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // sticky events; a new event in the read cycle survives the clear
  always @(posedge clk) begin
    if (!nrst) begin
      irq_st_r <= 5'h00;
      up_q_r <= 1'b0;
      lo_q_r <= 1'b0;
      oc_q_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      up_q_r <= upper_limit_flag_r;
      lo_q_r <= lower_limit_alarm_r;
      oc_q_r <= overcurrent_detect_flag_r;
      if (rd && addr == `PLCD_A_IRQST) begin
        irq_st_r <= ev;
      end else begin
        irq_st_r <= irq_st_r | ev;
      end
      irq_r <= |(irq_st_r & irq_msk_r);
    end
  end

  // read mux, data valid the cycle after the strobe
  always @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `PLCD_A_CTRL: rdata_r <= ctrl_r;
        `PLCD_A_UPLIM: rdata_r <= uplim_r;
        `PLCD_A_LOLIM: rdata_r <= lolim_r;
        `PLCD_A_PANSP: rdata_r <= pansp_r;
        `PLCD_A_DTIME: rdata_r <= dtime_r;
        `PLCD_A_OCLVL: rdata_r <= oclvl_r;
        `PLCD_A_OCPER: rdata_r <= ocper_r;
        `PLCD_A_BIAS: rdata_r <= bias_r;
        `PLCD_A_GAIN: rdata_r <= gain_r;
        `PLCD_A_STAT: begin
          rdata_r <= {11'h000, diff_enable_r, pid_active_r, overcurrent_detect_flag_r,
            lower_limit_alarm_r, upper_limit_flag_r};
        end
        `PLCD_A_IRQST: rdata_r <= {11'h000, irq_st_r};
        `PLCD_A_IRQMSK: rdata_r <= {11'h000, irq_msk_r};
        `PLCD_A_SPD: rdata_r <= speed_cmd_r;
        `PLCD_A_SPMAX: rdata_r <= spmax_r;
        `PLCD_A_SPMIN: rdata_r <= spmin_r;
        default: rdata_r <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: testbench/plcd_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// sensed motor current; a slow sensor adds one cycle of lag
module plcd_drive_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] cur_tgt,
  output var logic [15:0] out_current = 16'h0000
);
  logic [15:0] stage_r = 16'h0000; // extra stage of a sluggish sensor
  // the sensor never holds a stale reading longer than its lag
  always @(posedge clk) begin
    stage_r <= cur_tgt;
    out_current <= slow ? stage_r : cur_tgt;
  end
endmodule
`default_nettype wire

// File: testbench/plcd_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-side checks of the supervisory block
module plcd_chk #(parameter MS_DIV = 10) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic [15:0] rdata_r,
  input wire logic running,
  input wire logic speed_select_high,
  input wire logic speed_select_mid,
  input wire logic speed_select_low,
  input wire logic jog_input,
  input wire logic overcurrent_detect_flag_r,
  input wire logic pid_active_r,
  input wire logic diff_enable_r,
  input wire logic [15:0] diff_time_r
);
  int hold_cnt_r; // cycles the detect flag has stood high
  wire logic oc = overcurrent_detect_flag_r;
  wire logic ovr = speed_select_high | speed_select_mid | speed_select_low | jog_input;
  // count from the flag's rise; cleared whenever it is low
  always @(posedge clk) begin
    if (!nrst || !oc) begin
      hold_cnt_r <= 0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_oc_run;
    $rose(oc) |-> $past(running);
  endproperty
  a_oc_run: assert property (p_oc_run) else $error("flag rose while stopped");
  property p_oc_hold;
    $fell(oc) && $past(nrst) |-> hold_cnt_r >= 99 * MS_DIV - 2;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("flag dropped early");
  property p_oc_drop;
    oc && !running && hold_cnt_r > 101 * MS_DIV |-> ##[1:2] !oc;
  endproperty
  a_oc_drop: assert property (p_oc_drop) else $error("flag stuck after hold");
  property p_pid_ovr;
    ovr [*2] |-> !pid_active_r;
  endproperty
  a_pid_ovr: assert property (p_pid_ovr) else $error("pid kept under override");
  property p_dt_off;
    pid_active_r && !diff_enable_r |-> diff_time_r == 16'h0000;
  endproperty
  a_dt_off: assert property (p_dt_off) else $error("diff time while off");
  property p_dt_rng;
    diff_enable_r |-> diff_time_r >= 16'h0001 && diff_time_r <= 16'h03e8;
  endproperty
  a_dt_rng: assert property (p_dt_rng) else $error("diff time out of range");
  property p_rd_unm;
    rd && addr == 4'hf |=> rdata_r == 16'h0000;
  endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_rd_hold;
    !rd |=> $stable(rdata_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind plcd_top plcd_chk #(.MS_DIV(MS_DIV)) plcd_chk_i (.clk(clk), .nrst(nrst),
  .addr(addr), .rd(rd), .rdata_r(rdata_r), .running(running),
  .speed_select_high(speed_select_high), .speed_select_mid(speed_select_mid),
  .speed_select_low(speed_select_low), .jog_input(jog_input),
  .overcurrent_detect_flag_r(overcurrent_detect_flag_r), .pid_active_r(pid_active_r),
  .diff_enable_r(diff_enable_r), .diff_time_r(diff_time_r));
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "plcd_regs.vh"
// self-checking bench of the supervisory block
module tb;
  localparam int LIMIT = 20000; // tests need about 3000 cycles
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] fb = 16'h0000;
  logic [15:0] cur_tgt = 16'h0000; // current asked of the sensor
  logic [15:0] pspd = 16'h0000;
  logic running = 1'b0;
  logic tuning = 1'b0;
  logic psel = 1'b0;
  logic [3:0] sel = 4'h0; // high, mid, low, jog
  wire logic [15:0] rdata_r, cur, dtime, spt, spd;
  wire logic upf, loa, ocf, pida, dfe, irq;
  int mismatches = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int n;
  always #4 clk = ~clk;
  plcd_drive_model plcd_drive_model_i (.clk(clk), .slow(1'b1), .cur_tgt(cur_tgt),
    .out_current(cur));
  plcd_top #(.MS_DIV(10)) plcd_top_i (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .feedback(fb),
    .out_current(cur), .analog_sp(16'h0123), .pid_speed(pspd), .running(running),
    .tuning_active(tuning), .pid_select_input(psel), .speed_select_high(sel[0]),
    .speed_select_mid(sel[1]), .speed_select_low(sel[2]), .jog_input(sel[3]),
    .upper_limit_flag_r(upf), .lower_limit_alarm_r(loa), .overcurrent_detect_flag_r(ocf),
    .pid_active_r(pida), .diff_enable_r(dfe), .diff_time_r(dtime), .set_point_r(spt),
    .speed_cmd_r(spd), .irq_r(irq));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata_r);
  endtask
  // outputs are looked at mid-cycle, clear of the launching edge
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic wait_oc(input int c);
    n = 0;
    while (ocf !== 1'b1 && n < c) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // a hang counts against the run
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_chk("oclvl rst", `PLCD_A_OCLVL, 16'h05dc);
    rd_chk("ocper rst", `PLCD_A_OCPER, 16'h0000);
    rd_chk("uplim rst", `PLCD_A_UPLIM, 16'h270f);
    wr_reg(`PLCD_A_STAT, 16'hffff);
    rd_chk("stat ro", `PLCD_A_STAT, 16'h0000);
    rd_chk("unmapped", 4'hf, 16'h0000);
    wr_reg(`PLCD_A_OCLVL, 16'h0fff);
    rd_chk("oclvl clip", `PLCD_A_OCLVL, 16'h07d0);
    wr_reg(`PLCD_A_OCPER, 16'hffff);
    rd_chk("ocper clip", `PLCD_A_OCPER, 16'h2710);
    $display("test registers done");
    wr_reg(`PLCD_A_IRQMSK, 16'h0001);
    wr_reg(`PLCD_A_UPLIM, 16'h01f4);
    @(posedge clk) fb <= 16'h0201;
    // flag, then sticky bit, then the registered interrupt: three edges
    step(4);
    chk("up", 16'h0001, {15'h0, upf});
    chk("irq", 16'h0001, {15'h0, irq});
    rd_chk("irqst", `PLCD_A_IRQST, 16'h0001);
    step(3);
    chk("irq clr", 16'h0000, {15'h0, irq});
    @(posedge clk) fb <= 16'h0200;
    step(3);
    chk("up edge", 16'h0000, {15'h0, upf});
    wr_reg(`PLCD_A_UPLIM, 16'h270f);
    wr_reg(`PLCD_A_IRQMSK, 16'h0000);
    wr_reg(`PLCD_A_LOLIM, 16'h01f4);
    @(posedge clk) fb <= 16'h01ff;
    step(3);
    chk("up off", 16'h0000, {15'h0, upf});
    chk("lo", 16'h0001, {15'h0, loa});
    chk("irq masked", 16'h0000, {15'h0, irq});
    rd_chk("irqst lo", `PLCD_A_IRQST, 16'h0002);
    $display("test limits done");
    wr_reg(`PLCD_A_DTIME, 16'h0000);
    step(3);
    chk("dt min", 16'h0001, dtime);
    wr_reg(`PLCD_A_DTIME, 16'h0400);
    step(3);
    chk("dt max", 16'h03e8, dtime);
    wr_reg(`PLCD_A_DTIME, 16'h270f);
    step(3);
    chk("dt off", 16'h0000, {15'h0, dfe});
    @(posedge clk) running <= 1'b1;
    psel <= 1'b1;
    step(3);
    chk("pid on", 16'h0001, {15'h0, pida});
    chk("dt off pid", 16'h0000, {15'h0, dfe});
    chk("dt zero", 16'h0000, dtime);
    wr_reg(`PLCD_A_DTIME, 16'h0064);
    step(3);
    chk("dt on", 16'h0001, {15'h0, dfe});
    chk("dt val", 16'h0064, dtime);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) sel <= 4'h1 << i;
      step(3);
      chk("pid override", 16'h0000, {15'h0, pida});
      @(posedge clk) sel <= 4'h0;
    end
    wr_reg(`PLCD_A_CTRL, 16'h0006);
    step(3);
    chk("pid switchover", 16'h0000, {15'h0, pida});
    wr_reg(`PLCD_A_CTRL, 16'h0008);
    step(3);
    chk("pid tuning", 16'h0000, {15'h0, pida});
    wr_reg(`PLCD_A_PANSP, 16'h0200);
    step(3);
    chk("panel sp", 16'h0200, spt);
    wr_reg(`PLCD_A_CTRL, 16'h0020);
    step(3);
    chk("ext sp", 16'h0123, spt);
    wr_reg(`PLCD_A_BIAS, 16'h0064);
    wr_reg(`PLCD_A_GAIN, 16'h00c8);
    @(posedge clk) pspd <= 16'h0300;
    step(3);
    chk("spd gain", 16'h00c8, spd);
    @(posedge clk) pspd <= 16'h0010;
    step(3);
    chk("spd bias", 16'h0064, spd);
    wr_reg(`PLCD_A_SPMIN, 16'h0096);
    step(3);
    chk("spd min", 16'h0096, spd);
    wr_reg(`PLCD_A_SPMIN, 16'h0000);
    wr_reg(`PLCD_A_SPMAX, 16'h0050);
    step(3);
    chk("spd max", 16'h0050, spd);
    $display("test pid done");
    wr_reg(`PLCD_A_OCLVL, 16'h03e8);
    wr_reg(`PLCD_A_OCPER, 16'h0005);
    @(posedge clk) cur_tgt <= 16'h0400;
    step(150);
    chk("oc at rated", 16'h0000, {15'h0, ocf});
    @(posedge clk) cur_tgt <= 16'h0401;
    step(35);
    @(posedge clk) cur_tgt <= 16'h0400;
    @(posedge clk) cur_tgt <= 16'h0401;
    step(35);
    chk("oc restart", 16'h0000, {15'h0, ocf});
    wait_oc(40);
    chk("oc period", 16'h0001, {15'h0, ocf});
    @(posedge clk) cur_tgt <= 16'h0000;
    step(970);
    chk("oc hold", 16'h0001, {15'h0, ocf});
    step(60);
    chk("oc release", 16'h0000, {15'h0, ocf});
    wr_reg(`PLCD_A_OCPER, 16'h0000);
    @(posedge clk) tuning <= 1'b1;
    cur_tgt <= 16'h0401;
    step(480);
    chk("oc zero early", 16'h0000, {15'h0, ocf});
    wait_oc(60);
    chk("oc zero tune", 16'h0001, {15'h0, ocf});
    // past the hold the flag follows the excess, then stopping drops it
    step(1100);
    chk("oc while over", 16'h0001, {15'h0, ocf});
    @(posedge clk) running <= 1'b0;
    step(3);
    chk("oc stopped", 16'h0000, {15'h0, ocf});
    $display("test overcurrent done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
